// file: core/flash_seq_pkg.sv
// Constants and carrier types for the flash command sequencer.
// Assumes one 125 MHz clock and a flash array macro outside the block.
//
// Function
// [RULE_01] Phrase program writes four words, reads them back, then sets done.
// [RULE_02] Software gives a phrase address with the low three bits zero.
// [RULE_03] Phrase and once programming need object index 101 at launch.
// [RULE_04] A command not allowed in the present mode raises access error.
// [RULE_05] Phrase program with an invalid 18-bit address raises access error.
// [RULE_06] Phrase program into a protected area raises protection violation.
// [RULE_07] Verify sets verify error on read errors, uncorrectable on bad ones.
// [RULE_08] Once program loads 0x07, phrase index 0..7, then four data words.
// [RULE_09] Once program checks the phrase is blank, programs, verifies, done.
// [RULE_10] Once program on an already programmed phrase raises access error.
// [RULE_11] Once program with phrase index above seven raises access error.
// [RULE_12] A phrase programmed to all ones counts as blank again.
// [RULE_13] Program flash reads give invalid data while once programming.
// [RULE_14] Software issues once program once per phrase, not from that block.
// [RULE_15] Erase all is code 0x08 and needs object index 000 at launch.
// [RULE_16] Erase all erases everything, verifies, releases security if clean.
// [RULE_17] Software writes no flash register while erase all runs.
// [RULE_18] Erase all with any protected area raises protection violation.
// [RULE_19] Block erase loads 0x09 with block bits, then address in block.
// [RULE_20] Block erase erases the chosen block, verifies, then sets done.
// [RULE_21] Phrase program loads 0x06 with block bits, address, four words.
// [RULE_22] A launch error starts nothing and leaves the done flag set.

package flash_seq_pkg;

	////////////////////////////////////////////////////////////////////////
	// Command codes and launch indices
	localparam logic [7:0] CMD_PROG_PHRASE = 8'h06;
	localparam logic [7:0] CMD_PROG_ONCE   = 8'h07;
	localparam logic [7:0] CMD_ERASE_ALL   = 8'h08;
	localparam logic [7:0] CMD_ERASE_BLOCK = 8'h09;
	localparam logic [2:0] IDX_PROGRAM     = 3'h5;
	localparam logic [2:0] IDX_ERASE_ALL   = 3'h0;
	localparam logic [2:0] IDX_ERASE_BLOCK = 3'h1;
	localparam int         OBJ_WORDS       = 6;

	////////////////////////////////////////////////////////////////////////
	// Flash space layout: block select is global address [17:16]
	localparam logic [1:0]  BLK_DATA      = 2'h0;
	localparam logic [1:0]  BLK_UNUSED    = 2'h1;
	localparam logic [15:0] DATA_LIMIT    = 16'h1000;
	localparam logic [15:0] ONCE_LIMIT    = 16'h0008;
	localparam logic [63:0] PHRASE_ERASED = 64'hFFFF_FFFF_FFFF_FFFF;

	////////////////////////////////////////////////////////////////////////
	// Register byte offsets
	localparam logic [7:0] REG_STATUS   = 8'h00;
	localparam logic [7:0] REG_INDEX    = 8'h04;
	localparam logic [7:0] REG_OBJECT   = 8'h08;
	localparam logic [7:0] REG_PROTECT  = 8'h0C;
	localparam logic [7:0] REG_MODE     = 8'h10;
	localparam logic [7:0] REG_SECURITY = 8'h14;

	// Status register bit positions
	localparam int ST_DONE   = 7;
	localparam int ST_ACCESS = 5;
	localparam int ST_PROT   = 4;
	localparam int ST_VERIFY = 1;
	localparam int ST_UNCORR = 0;

	// Protect register: [0] data flash, [1] program flash, [15:8] base
	localparam int PR_DATA   = 0;
	localparam int PR_PROG   = 1;
	localparam int PR_BASE_L = 8;
	localparam int PR_BASE_H = 15;

	// Mode register: 0 normal, 1 special
	localparam logic MODE_NORMAL  = 1'b0;
	localparam logic MODE_SPECIAL = 1'b1;

	// Reset values
	localparam logic [15:0] PROTECT_RESET = 16'h0000;
	localparam logic        MODE_RESET    = 1'b0;
	localparam logic        SECURE_RESET  = 1'b1;
	localparam logic [2:0]  INDEX_RESET   = 3'h0;

	////////////////////////////////////////////////////////////////////////
	// Carrier types
	typedef enum logic [2:0] {
		OP_READ, OP_PROGRAM, OP_ERASE_BLOCK, OP_ERASE_ALL,
		OP_VERIFY_BLOCK, OP_VERIFY_ALL
	} flashOp_t;

	typedef struct packed {
		logic        start;
		flashOp_t    op;
		logic        info;
		logic [17:0] addr;
		logic [63:0] data;
	} flashReq_t;

	typedef struct packed {
		logic        done;
		logic [63:0] rdata;
		logic        err;
		logic        uncorr;
	} flashRsp_t;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [7:0]  addr;
		logic [31:0] wdata;
	} regAccess_t;

endpackage

// file: core/ahb_reg_port.sv
// AHB-Lite slave front end for the sequencer registers.
// Assumes a single master; one wait state on every word transfer, none on other sizes.
`timescale 1ns/10ps

module ahb_reg_port (
	input  wire logic                      clock,
	input  wire logic                      nrst,
	input  wire logic                      hsel,
	input  wire logic [31:0]               haddr,
	input  wire logic [1:0]                htrans,
	input  wire logic                      hwrite,
	input  wire logic [2:0]                hsize,
	input  wire logic [31:0]               hwdata,
	input  wire logic                      hready,
	output logic                           hreadyout,
	output logic [31:0]                    hrdata,
	output logic                           hresp,
	output flash_seq_pkg::regAccess_t      access,
	input  wire logic [31:0]               rdValue
);

	logic       pending_q;
	logic       pendWrite_q;
	logic [7:0] pendAddr_q;
	logic       takeAddr;

	////////////////////////////////////////////////////////////////////////
	// Address phase capture, word transfers only
	assign takeAddr = hsel && htrans[1] && hready && (hsize == 3'h2);

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			pending_q   <= 1'b0;
			pendWrite_q <= 1'b0;
			pendAddr_q  <= 8'h00;
		end else if (takeAddr) begin
			pending_q   <= 1'b1;
			pendWrite_q <= hwrite;
			pendAddr_q  <= {haddr[7:2], 2'h0};
		end else if (pending_q) begin
			pending_q <= 1'b0;
		end
	end

	// Data phase: one low cycle of ready, then the answer
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			hreadyout <= 1'b1;
			hrdata    <= 32'h0000_0000;
			hresp     <= 1'b0;
		end else begin
			hresp <= 1'b0;
			if (takeAddr) begin
				hreadyout <= 1'b0;
			end else if (pending_q) begin
				hreadyout <= 1'b1;
				hrdata    <= pendWrite_q ? 32'h0000_0000 : rdValue;
			end
		end
	end

	// Register access strobe toward the core
	always_comb begin
		access.wr    = pending_q && pendWrite_q;
		access.rd    = pending_q && !pendWrite_q;
		access.addr  = pendAddr_q;
		access.wdata = hwdata;
	end

endmodule

// file: core/cmd_launch_check.sv
// Launch checks for the flash commands: index, mode, address, protection.
// Assumes the command object words are stable while it is read.
`timescale 1ns/10ps

module cmd_launch_check (
	input  wire logic [15:0] objCmd,
	input  wire logic [15:0] objAddr,
	input  wire logic [2:0]  index,
	input  wire logic        mode,
	input  wire logic [15:0] protect,
	output logic             access_error,
	output logic             protErr
);

	logic [7:0] code;
	logic [1:0] blk;

	// Block select decode, used for several commands
	function automatic logic blockValid(input logic [1:0] b);
		blockValid = (b != flash_seq_pkg::BLK_UNUSED);
	endfunction

	// Commands allowed in each operating mode
	function automatic logic cmdAllowed(input logic [7:0] c, input logic m);
		unique case (c)
			flash_seq_pkg::CMD_ERASE_ALL:
				cmdAllowed = (m == flash_seq_pkg::MODE_SPECIAL);
			default:
				cmdAllowed = 1'b1;
		endcase
	endfunction

	// Protection of one address of a block
	function automatic logic isProtected(input logic [1:0] b,
			input logic [15:0] a, input logic [15:0] p);
		if (b == flash_seq_pkg::BLK_DATA) begin
			isProtected = p[flash_seq_pkg::PR_DATA];
		end else begin
			isProtected = p[flash_seq_pkg::PR_PROG] &&
				({b, a[15:10]} >=
				p[flash_seq_pkg::PR_BASE_H:flash_seq_pkg::PR_BASE_L]);
		end
	endfunction

	assign code = objCmd[15:8];
	assign blk  = objCmd[1:0];

	////////////////////////////////////////////////////////////////////////
	// Per-command decision
	always_comb begin
		access_error  = !cmdAllowed(code, mode); // RULE_04
		protErr = 1'b0;
		unique case (code)
			flash_seq_pkg::CMD_PROG_PHRASE: begin
				if (index != flash_seq_pkg::IDX_PROGRAM)
					access_error = 1'b1; // RULE_03
				if (!blockValid(blk) || (blk == flash_seq_pkg::BLK_DATA &&
						objAddr >= flash_seq_pkg::DATA_LIMIT))
					access_error = 1'b1; // RULE_05
				if (objAddr[2:0] != 3'h0)
					access_error = 1'b1; // RULE_02
				protErr = isProtected(blk, objAddr, protect); // RULE_06
			end
			flash_seq_pkg::CMD_PROG_ONCE: begin
				if (index != flash_seq_pkg::IDX_PROGRAM)
					access_error = 1'b1; // RULE_03
				if (objAddr >= flash_seq_pkg::ONCE_LIMIT)
					access_error = 1'b1; // RULE_11
			end
			flash_seq_pkg::CMD_ERASE_ALL: begin
				if (index != flash_seq_pkg::IDX_ERASE_ALL)
					access_error = 1'b1; // RULE_15
				protErr = protect[flash_seq_pkg::PR_DATA] ||
					protect[flash_seq_pkg::PR_PROG]; // RULE_18
			end
			flash_seq_pkg::CMD_ERASE_BLOCK: begin
				if (index != flash_seq_pkg::IDX_ERASE_BLOCK)
					access_error = 1'b1;
				if (!blockValid(blk))
					access_error = 1'b1;
				if (blk == flash_seq_pkg::BLK_DATA)
					protErr = protect[flash_seq_pkg::PR_DATA];
				else
					protErr = protect[flash_seq_pkg::PR_PROG];
			end
			default: access_error = 1'b1;
		endcase
	end

endmodule

// file: core/flash_program_erase_sequencer.sv
// Flash program and erase command sequencer with AHB-Lite registers.
// Assumes a flash array macro that takes one-cycle start requests and
// answers each with a one-cycle done pulse carrying read data and errors.
//
// Decided for this implementation: the address map and the AHB-Lite register port.
`timescale 1ns/10ps

module flash_program_erase_sequencer (
	input  wire logic                  clock,
	input  wire logic                  nrst,
	input  wire logic                  hsel,
	input  wire logic [31:0]           haddr,
	input  wire logic [1:0]            htrans,
	input  wire logic                  hwrite,
	input  wire logic [2:0]            hsize,
	input  wire logic [31:0]           hwdata,
	input  wire logic                  hready,
	output logic                       hreadyout,
	output logic [31:0]                hrdata,
	output logic                       hresp,
	output flash_seq_pkg::flashReq_t   flashReq,
	input  wire flash_seq_pkg::flashRsp_t flashRsp,
	output logic                       readInvalid,
	output logic                       secure
);

	typedef enum logic [2:0] {
		S_IDLE, S_BLANK, S_PROG, S_READBACK, S_ERASE, S_ERASE_VFY
	} seqState_t;

	flash_seq_pkg::regAccess_t access;
	logic [31:0]               rdValue;

	seqState_t                 state_q;
	flash_seq_pkg::flashReq_t  req_q;
	logic                      done_q;
	logic                      access_error_q;
	logic                      protViol_q;
	logic                      verifyErr_q;
	logic                      uncorrErr_q;
	logic [2:0]                index_q;
	logic [15:0]               obj_q [flash_seq_pkg::OBJ_WORDS];
	logic [15:0]               protect_q;
	logic                      mode_q;
	logic                      secure_q;
	logic                      onceRun_q;

	logic                      chkAcc;
	logic                      chkProt;
	logic                      wrStatus;
	logic                      launchReq;
	logic                      launchOk;
	logic                      launchBad;
	logic                      finish;
	logic                      blankFail;
	logic                      vfyErr;
	logic                      vfyUncorr;
	logic                      eraseClean;
	logic [7:0]                code;
	logic [63:0]               phrase;

	////////////////////////////////////////////////////////////////////////
	// Bus slave and launch checks
	ahb_reg_port busPort (
		.clock     (clock),
		.nrst      (nrst),
		.hsel      (hsel),
		.haddr     (haddr),
		.htrans    (htrans),
		.hwrite    (hwrite),
		.hsize     (hsize),
		.hwdata    (hwdata),
		.hready    (hready),
		.hreadyout (hreadyout),
		.hrdata    (hrdata),
		.hresp     (hresp),
		.access    (access),
		.rdValue   (rdValue)
	);

	cmd_launch_check launchCheck (
		.objCmd  (obj_q[0]),
		.objAddr (obj_q[1]),
		.index   (index_q),
		.mode    (mode_q),
		.protect (protect_q),
		.access_error  (chkAcc),
		.protErr (chkProt)
	);

	////////////////////////////////////////////////////////////////////////
	// Launch decode: writing one to the done bit while it is set
	assign code     = obj_q[0][15:8];
	assign phrase   = {obj_q[5], obj_q[4], obj_q[3], obj_q[2]};
	assign wrStatus = access.wr && (access.addr == flash_seq_pkg::REG_STATUS);

	always_comb begin
		launchReq = wrStatus && access.wdata[flash_seq_pkg::ST_DONE] &&
			done_q && (state_q == S_IDLE) &&
			(!access_error_q || access.wdata[flash_seq_pkg::ST_ACCESS]) &&
			(!protViol_q || access.wdata[flash_seq_pkg::ST_PROT]);
		launchBad = launchReq && (chkAcc || chkProt);
		launchOk  = launchReq && !chkAcc && !chkProt; // RULE_22
	end

	////////////////////////////////////////////////////////////////////////
	// Completion and verify outcome of the running command
	always_comb begin
		finish     = 1'b0;
		blankFail  = 1'b0;
		vfyErr     = 1'b0;
		vfyUncorr  = 1'b0;
		eraseClean = 1'b0;
		if (flashRsp.done) begin
			unique case (state_q)
				S_BLANK: begin
					// All ones counts as blank, anything else refuses
					blankFail = (flashRsp.rdata != flash_seq_pkg::PHRASE_ERASED)
						|| flashRsp.err; // RULE_10 RULE_12
					finish = blankFail;
				end
				S_READBACK: begin
					finish    = 1'b1;
					vfyErr    = flashRsp.err || (flashRsp.rdata != req_q.data); // RULE_07
					vfyUncorr = flashRsp.uncorr; // RULE_07
				end
				S_ERASE_VFY: begin
					finish     = 1'b1;
					vfyErr     = flashRsp.err || flashRsp.uncorr; // RULE_07
					vfyUncorr  = flashRsp.uncorr; // RULE_07
					eraseClean = (req_q.op == flash_seq_pkg::OP_VERIFY_ALL) &&
						!flashRsp.err && !flashRsp.uncorr;
				end
				default: finish = 1'b0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sequencer state and flash requests
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			state_q <= S_IDLE;
			req_q   <= '0;
		end else begin
			req_q.start <= 1'b0;
			unique case (state_q)
				S_IDLE: begin
					if (launchOk) begin
						req_q.start <= 1'b1;
						req_q.info  <= 1'b0;
						req_q.data  <= phrase;
						req_q.addr  <= {obj_q[0][1:0], obj_q[1]};
						unique case (code)
							flash_seq_pkg::CMD_PROG_PHRASE: begin
								state_q  <= S_PROG; // RULE_01
								req_q.op <= flash_seq_pkg::OP_PROGRAM;
							end
							flash_seq_pkg::CMD_PROG_ONCE: begin
								// Blank check of the reserved phrase first
								state_q    <= S_BLANK; // RULE_09
								req_q.op   <= flash_seq_pkg::OP_READ;
								req_q.info <= 1'b1;
								req_q.addr <= {obj_q[1][14:0], 3'h0};
							end
							flash_seq_pkg::CMD_ERASE_ALL: begin
								state_q  <= S_ERASE; // RULE_16
								req_q.op <= flash_seq_pkg::OP_ERASE_ALL;
							end
							default: begin
								state_q  <= S_ERASE; // RULE_20
								req_q.op <= flash_seq_pkg::OP_ERASE_BLOCK;
							end
						endcase
					end
				end
				S_BLANK: begin
					if (flashRsp.done) begin
						if (blankFail) begin
							state_q <= S_IDLE;
						end else begin
							state_q     <= S_PROG; // RULE_09
							req_q.start <= 1'b1;
							req_q.op    <= flash_seq_pkg::OP_PROGRAM;
						end
					end
				end
				S_PROG: begin
					// Read back the same phrase after programming
					if (flashRsp.done) begin
						state_q     <= S_READBACK; // RULE_01 RULE_09
						req_q.start <= 1'b1;
						req_q.op    <= flash_seq_pkg::OP_READ;
					end
				end
				S_READBACK: begin
					if (flashRsp.done)
						state_q <= S_IDLE;
				end
				S_ERASE: begin
					if (flashRsp.done) begin
						state_q     <= S_ERASE_VFY; // RULE_16 RULE_20
						req_q.start <= 1'b1;
						if (req_q.op == flash_seq_pkg::OP_ERASE_ALL)
							req_q.op <= flash_seq_pkg::OP_VERIFY_ALL;
						else
							req_q.op <= flash_seq_pkg::OP_VERIFY_BLOCK;
					end
				end
				S_ERASE_VFY: begin
					if (flashRsp.done)
						state_q <= S_IDLE;
				end
				default: state_q <= S_IDLE;
			endcase
		end
	end

	assign flashReq = req_q;

	////////////////////////////////////////////////////////////////////////
	// Done flag: cleared by a good launch, set when the command ends
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst)
			done_q <= 1'b1;
		else if (finish)
			done_q <= 1'b1; // RULE_01 RULE_20
		else if (launchOk)
			done_q <= 1'b0; // RULE_09
	end

	// Launch errors; a setting event wins over a write-one clear
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			access_error_q   <= 1'b0;
			protViol_q <= 1'b0;
		end else begin
			if ((launchBad && chkAcc) || blankFail)
				access_error_q <= 1'b1; // RULE_10
			else if (wrStatus && access.wdata[flash_seq_pkg::ST_ACCESS])
				access_error_q <= 1'b0;
			if (launchBad && chkProt)
				protViol_q <= 1'b1; // RULE_06 RULE_18
			else if (wrStatus && access.wdata[flash_seq_pkg::ST_PROT])
				protViol_q <= 1'b0;
		end
	end

	// Verify outcome flags, cleared at each good launch
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			verifyErr_q <= 1'b0;
			uncorrErr_q <= 1'b0;
		end else if (launchOk) begin
			verifyErr_q <= 1'b0;
			uncorrErr_q <= 1'b0;
		end else if (finish && !blankFail) begin
			verifyErr_q <= vfyErr; // RULE_07
			uncorrErr_q <= vfyUncorr; // RULE_07
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Command object and configuration, frozen while a command runs
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			index_q <= flash_seq_pkg::INDEX_RESET;
		end else if (access.wr && done_q &&
				access.addr == flash_seq_pkg::REG_INDEX) begin
			index_q <= access.wdata[2:0];
		end
	end

	generate
		for (genvar w = 0; w < flash_seq_pkg::OBJ_WORDS; w++) begin : gObj
			always_ff @(posedge clock or negedge nrst) begin
				if (!nrst)
					obj_q[w] <= 16'h0000;
				else if (access.wr && done_q && index_q == 3'(w) &&
						access.addr == flash_seq_pkg::REG_OBJECT)
					obj_q[w] <= access.wdata[15:0];
			end
		end
	endgenerate

	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			protect_q <= flash_seq_pkg::PROTECT_RESET;
			mode_q    <= flash_seq_pkg::MODE_RESET;
		end else if (access.wr && done_q) begin
			if (access.addr == flash_seq_pkg::REG_PROTECT)
				protect_q <= access.wdata[15:0];
			if (access.addr == flash_seq_pkg::REG_MODE)
				mode_q <= access.wdata[0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Security released only by a clean erase-all verify
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst)
			secure_q <= flash_seq_pkg::SECURE_RESET;
		else if (eraseClean)
			secure_q <= 1'b0; // RULE_16
	end

	assign secure = secure_q;

	// Program flash reads are invalid during once programming
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst)
			onceRun_q <= 1'b0;
		else if (launchOk && code == flash_seq_pkg::CMD_PROG_ONCE)
			onceRun_q <= 1'b1; // RULE_13
		else if (finish)
			onceRun_q <= 1'b0;
	end

	assign readInvalid = onceRun_q;

	////////////////////////////////////////////////////////////////////////
	// Register read mux; unmapped offsets read zero
	always_comb begin
		rdValue = 32'h0000_0000;
		unique case (access.addr)
			flash_seq_pkg::REG_STATUS: begin
				rdValue[flash_seq_pkg::ST_DONE]   = done_q;
				rdValue[flash_seq_pkg::ST_ACCESS] = access_error_q;
				rdValue[flash_seq_pkg::ST_PROT]   = protViol_q;
				rdValue[flash_seq_pkg::ST_VERIFY] = verifyErr_q;
				rdValue[flash_seq_pkg::ST_UNCORR] = uncorrErr_q;
			end
			flash_seq_pkg::REG_INDEX:    rdValue[2:0] = index_q;
			flash_seq_pkg::REG_OBJECT: begin
				if (index_q < 3'(flash_seq_pkg::OBJ_WORDS))
					rdValue[15:0] = obj_q[index_q];
			end
			flash_seq_pkg::REG_PROTECT:  rdValue[15:0] = protect_q;
			flash_seq_pkg::REG_MODE:     rdValue[0] = mode_q;
			flash_seq_pkg::REG_SECURITY: rdValue[0] = secure_q;
			default:                     rdValue = 32'h0000_0000;
		endcase
	end

endmodule

// file: testbench/flash_seq_monitor.sv
// Checker on the flash sequencer ports: bus timing and array requests.
// Bound to the top module by the statement after the module.
`timescale 1ns/10ps

module flash_seq_monitor (
	input wire logic	clock,
	input wire logic	nrst,
	input wire logic	hsel,
	input wire logic [1:0]	htrans,
	input wire logic [2:0]	hsize,
	input wire logic	hready,
	input wire logic	hreadyout,
	input wire logic	hresp,
	input wire flash_seq_pkg::flashReq_t	flashReq,
	input wire flash_seq_pkg::flashRsp_t	flashRsp,
	input wire logic	readInvalid,
	input wire logic	secure
);
	// Clock, reset and shorthands
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!nrst);
	logic	taken, clean;
	flash_seq_pkg::flashOp_t	op;
	assign taken = hsel && htrans[1] && hready && hsize == 3'h2;
	assign op = flashReq.op;
	assign clean = flashRsp.done && op == flash_seq_pkg::OP_VERIFY_ALL &&
		!flashRsp.err && !flashRsp.uncorr;

	////////////////////////////////////////////////////////////////////////
	// Bus answers and array handshake
	a_resp_okay: assert property (hresp == 1'b0)
		else $error("Response not OKAY");
	a_one_wait: assert property (taken |=> !hreadyout ##1 hreadyout)
		else $error("Data phase not two cycles");
	a_start_pulse: assert property (flashReq.start |=> !flashReq.start)
		else $error("Array start longer than one cycle");
	a_prog_readback: assert property (
		flashRsp.done && op == flash_seq_pkg::OP_PROGRAM |=>
		flashReq.start && op == flash_seq_pkg::OP_READ)
		else $error("No read back after program");
	a_erase_verify: assert property (
		flashRsp.done && (op == flash_seq_pkg::OP_ERASE_ALL ||
		op == flash_seq_pkg::OP_ERASE_BLOCK) |=>
		flashReq.start && op == $past(op) + 3'h2)
		else $error("No verify after erase");
	a_prog_aligned: assert property (
		flashReq.start && op == flash_seq_pkg::OP_PROGRAM && !flashReq.info
		|-> flashReq.addr[2:0] == 3'h0 && flashReq.addr[17:16] != 2'h1)
		else $error("Program to bad address");
	a_once_hides: assert property (
		flashReq.start && flashReq.info && op == flash_seq_pkg::OP_PROGRAM
		|-> readInvalid)
		else $error("Reads valid during once program");
	a_once_refused: assert property (
		flashRsp.done && op == flash_seq_pkg::OP_READ && flashReq.info &&
		flashRsp.rdata != flash_seq_pkg::PHRASE_ERASED |=> !flashReq.start)
		else $error("Used phrase programmed again");
	a_secure_clean: assert property (
		$fell(secure) |-> $past(clean))
		else $error("Security released without clean verify");
	c_program: cover property (flashReq.start && op == flash_seq_pkg::OP_PROGRAM);
	c_once: cover property (flashReq.start && flashReq.info);
	c_unsecure: cover property ($fell(secure));
endmodule

bind flash_program_erase_sequencer flash_seq_monitor monitor (
	.clock(clock), .nrst(nrst), .hsel(hsel), .htrans(htrans),
	.hsize(hsize), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
	.flashReq(flashReq), .flashRsp(flashRsp),
	.readInvalid(readInvalid), .secure(secure));

// file: testbench/flash_program_erase_sequencer_tb.sv
// Self-checking bench for the flash command sequencer.
// Assumes the bound checker; the bench also models the flash array.
`timescale 1ns/10ps

module flash_program_erase_sequencer_tb;
	logic	clock = 1'b0;
	logic	nrst = 1'b0;
	logic	hsel = 1'b1;
	logic	hwrite = 1'b0;
	logic	hready, hreadyout, hresp, readInvalid, secure;
	logic [1:0]	htrans = 2'h0;
	logic [2:0]	hsize = 3'h2;
	logic [31:0]	haddr = 32'h0, hwdata = 32'h0, hrdata;
	logic [63:0]	mem [logic [18:0]];
	logic [18:0]	k;
	logic	pend = 1'b0, errInj = 1'b0, uncInj = 1'b0;
	flash_seq_pkg::flashReq_t	flashReq;
	flash_seq_pkg::flashRsp_t	flashRsp = '0, r;
	int	fails = 0, checked = 0, cycles = 0;

	// Clock, single slave ready and the design
	initial begin
		forever #4 clock = ~clock;
	end
	assign hready = hreadyout;
	flash_program_erase_sequencer dut (.clock(clock), .nrst(nrst),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
		.flashReq(flashReq), .flashRsp(flashRsp),
		.readInvalid(readInvalid), .secure(secure));

	// Flash array: one done pulse two cycles after each start
	always @(posedge clock) begin
		pend <= flashReq.start;
		k = {flashReq.info, flashReq.addr};
		r = '0;
		r.done = pend;
		r.err = pend & errInj;
		r.uncorr = pend & uncInj;
		if (pend) begin
			case (flashReq.op)
				flash_seq_pkg::OP_PROGRAM: mem[k] = flashReq.data;
				flash_seq_pkg::OP_READ: r.rdata = mem.exists(k) ?
					mem[k] : flash_seq_pkg::PHRASE_ERASED;
				flash_seq_pkg::OP_ERASE_ALL: mem.delete();
				flash_seq_pkg::OP_ERASE_BLOCK: mem.delete();
				default: ;
			endcase
		end
		flashRsp <= r;
	end

	////////////////////////////////////////////////////////////////////////
	// One AHB-Lite single word transfer
	task automatic bus(input logic wr, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= wr;
		do @(posedge clock); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clock); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic cmp(input logic [63:0] g, input logic [63:0] e);
		checked++;
		if (g !== e) begin
			fails++;
			$display("MISMATCH %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic chk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		cmp({32'h0, q}, {32'h0, e});
	endtask

	// Load object words, launch, poll until done, check status, clear access and protection flags
	task automatic run(input logic [15:0] w0, w1, dw, input logic [2:0] ix,
		input logic [31:0] st);
		logic [31:0] q;
		for (int i = 0; i < flash_seq_pkg::OBJ_WORDS; i++) begin
			wr(flash_seq_pkg::REG_INDEX, i);
			wr(flash_seq_pkg::REG_OBJECT,
				{16'h0, i == 0 ? w0 : (i == 1 ? w1 : dw)});
		end
		wr(flash_seq_pkg::REG_INDEX, {29'h0, ix});
		wr(flash_seq_pkg::REG_STATUS, 32'h80);
		q = 32'h0;
		while (q[flash_seq_pkg::ST_DONE] !== 1'b1)
			bus(1'b0, flash_seq_pkg::REG_STATUS, 32'h0, q);
		cmp({32'h0, q}, {32'h0, st});
		wr(flash_seq_pkg::REG_STATUS, 32'h30);
	endtask

	task automatic final_report;
		if (fails == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// Hang guard
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			fails++;
			final_report;
		end
	end

	// Reset, then command scenarios in turn
	initial begin
		repeat (8) @(posedge clock);
		nrst <= 1'b1;
		@(posedge clock);
		chk(flash_seq_pkg::REG_STATUS, 32'h80);
		chk(flash_seq_pkg::REG_SECURITY, 32'h1);
		chk(8'h40, 32'h0);
		run(16'h0600, 16'h0010, 16'h1234, 3'h5, 32'h80);
		cmp(mem[19'h00010], {4{16'h1234}});
		run(16'h0600, 16'h0014, 16'h1234, 3'h5, 32'hA0);
		run(16'h0600, 16'h0018, 16'h1234, 3'h4, 32'hA0);
		run(16'h0601, 16'h0018, 16'h1234, 3'h5, 32'hA0);
		run(16'h0600, 16'h1000, 16'h1234, 3'h5, 32'hA0);
		wr(flash_seq_pkg::REG_PROTECT, 32'hA002);
		run(16'h0602, 16'h8000, 16'h1234, 3'h5, 32'h90);
		run(16'h0602, 16'h7FF8, 16'h1234, 3'h5, 32'h80);
		wr(flash_seq_pkg::REG_PROTECT, 32'h0);
		errInj = 1'b1;
		run(16'h0600, 16'h0020, 16'h1234, 3'h5, 32'h82);
		uncInj = 1'b1;
		run(16'h0600, 16'h0028, 16'h1234, 3'h5, 32'h83);
		errInj = 1'b0;
		uncInj = 1'b0;
		run(16'h0700, 16'h0003, 16'h5A5A, 3'h5, 32'h80);
		cmp(mem[19'h40018], {4{16'h5A5A}});
		run(16'h0700, 16'h0003, 16'h0F0F, 3'h5, 32'hA0);
		run(16'h0700, 16'h0008, 16'h0F0F, 3'h5, 32'hA0);
		run(16'h0700, 16'h0002, 16'h0F0F, 3'h0, 32'hA0);
		run(16'h0700, 16'h0007, 16'hFFFF, 3'h5, 32'h80);
		run(16'h0700, 16'h0007, 16'h0F0F, 3'h5, 32'h80);
		cmp(mem[19'h40038], {4{16'h0F0F}});
		run(16'h0800, 16'h0, 16'h0, 3'h0, 32'hA0);
		wr(flash_seq_pkg::REG_MODE, 32'h1);
		wr(flash_seq_pkg::REG_PROTECT, 32'h1);
		run(16'h0800, 16'h0, 16'h0, 3'h0, 32'h90);
		wr(flash_seq_pkg::REG_PROTECT, 32'h0);
		run(16'h0800, 16'h0, 16'h0, 3'h1, 32'hA0);
		errInj = 1'b1;
		run(16'h0800, 16'h0, 16'h0, 3'h0, 32'h82);
		chk(flash_seq_pkg::REG_SECURITY, 32'h1);
		errInj = 1'b0;
		run(16'h0902, 16'h0, 16'h0, 3'h1, 32'h80);
		run(16'h0800, 16'h0, 16'h0, 3'h0, 32'h80);
		chk(flash_seq_pkg::REG_SECURITY, 32'h0);
		final_report;
	end
endmodule
